/* File: enc_emu_pkg.sv */
// Package for the encoder pulse output emulator.
// Assumes a 100 MHz pclk and an APB master of 32-bit data.
package enc_emu_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_PULSE_COUNT  = 12'h000;
	localparam logic [11:0] ADDR_PHASE_SPEC   = 12'h004;
	localparam logic [11:0] ADDR_MON_SEL_1    = 12'h008;
	localparam logic [11:0] ADDR_MON_SEL_2    = 12'h00C;
	localparam logic [11:0] ADDR_STATUS       = 12'h010;
	localparam logic [11:0] ADDR_REV_COUNT    = 12'h014;

	// ------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------
	localparam logic [15:0] RST_PULSE_COUNT   = 16'h1000;
	localparam logic [1:0]  RST_PHASE_SPEC    = 2'h0;
	localparam logic [1:0]  RST_MON_SEL       = 2'h0;
	localparam int          PHASE_REV_BIT     = 0;
	localparam int          SPEC_DIRECT_BIT   = 1;

	// Monitor selections
	localparam logic [1:0]  MON_SPEED         = 2'h0;
	localparam logic [1:0]  MON_POSITION      = 2'h1;
	localparam logic [1:0]  MON_QUAD_STATE    = 2'h2;
	localparam logic [1:0]  MON_PULSE_COUNT   = 2'h3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CLK_MHZ           = 100;
	localparam int          ZERO_WIDTH_US     = 400;
	localparam int          ZERO_WIDTH_CYC    = ZERO_WIDTH_US * CLK_MHZ;

	// Differential output bundle
	typedef struct packed {
		logic a_true;
		logic a_inv;
		logic b_true;
		logic b_inv;
		logic z_true;
		logic z_inv;
	} diff_out_t;

endpackage

/* File: encoder_pulse_output_emulator.sv */
// Encoder pulse output emulator: A/B quadrature, zero mark, monitors.
// Assumes encoder inputs from pins (synchronised here) and an APB master.
module encoder_pulse_output_emulator #(
	parameter int          ENC_RES        = 4096,
	parameter int          ZERO_WIDTH     = enc_emu_pkg::ZERO_WIDTH_CYC
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   enc_step,
	input  wire logic                   enc_dir_ccw,
	input  wire logic                   enc_zero,
	input  wire logic [9:0]             motor_speed,
	output enc_emu_pkg::diff_out_t      line_out,
	output logic      [9:0]             monitor_out_first,
	output logic      [9:0]             monitor_out_second
);

	// Elaboration checks
	if (ENC_RES < 4 || ENC_RES > 65535) begin : g_bad_res
		$error("ENC_RES out of range");
	end
	if (ZERO_WIDTH < 1 || ZERO_WIDTH > 16777215) begin : g_bad_zw
		$error("ZERO_WIDTH out of range");
	end

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync_prev;
	logic       step_sync;
	logic       dir_sync;
	logic       zero_sync;
	logic       step_evt;
	logic       zero_evt;

	// Two flops per pin, then a third stage for edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1     <= 3'h0;
			sync2     <= 3'h0;
			sync_prev <= 3'h0;
		end else begin
			sync1     <= {enc_zero, enc_dir_ccw, enc_step};
			sync2     <= sync1;
			sync_prev <= sync2;
		end
	end

	// Synchronised levels and rising edges
	assign step_sync = sync2[0];
	assign dir_sync  = sync2[1];
	assign zero_sync = sync2[2];
	assign step_evt  = step_sync & ~sync_prev[0];
	assign zero_evt  = zero_sync & ~sync_prev[2];

	// ------------------------------------------------------------
	// Registers and APB slave
	// ------------------------------------------------------------
	logic [15:0] pulse_count_setting;
	logic [1:0]  phase_spec_setting;
	logic [1:0]  monitor_select_first;
	logic [1:0]  monitor_select_second;
	logic [15:0] next_pulse_count;
	logic [1:0]  next_phase_spec;
	logic [1:0]  next_mon_sel_1;
	logic [1:0]  next_mon_sel_2;
	logic        wr_en;
	logic        addr_ok;
	logic [15:0] rev_count;
	logic [15:0] next_rev_count;

	// Zero wait states; unmapped access flags an error
	assign wr_en   = psel & penable & pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	// Address decode and read mux
	always_comb begin
		addr_ok = 1'b1;
		prdata  = 32'h0000_0000;
		case (paddr)
			enc_emu_pkg::ADDR_PULSE_COUNT: prdata[15:0] = pulse_count_setting;
			enc_emu_pkg::ADDR_PHASE_SPEC:  prdata[1:0]  = phase_spec_setting;
			enc_emu_pkg::ADDR_MON_SEL_1:   prdata[1:0]  = monitor_select_first;
			enc_emu_pkg::ADDR_MON_SEL_2:   prdata[1:0]  = monitor_select_second;
			enc_emu_pkg::ADDR_STATUS:
				prdata[3:0] = {line_out.z_true, line_out.b_true,
				               line_out.a_true, dir_sync};
			enc_emu_pkg::ADDR_REV_COUNT:   prdata[15:0] = rev_count;
			default:                       addr_ok = 1'b0;
		endcase
	end

	// Register write next values
	always_comb begin
		next_pulse_count = pulse_count_setting;
		next_phase_spec  = phase_spec_setting;
		next_mon_sel_1   = monitor_select_first;
		next_mon_sel_2   = monitor_select_second;
		if (wr_en) begin
			case (paddr)
				enc_emu_pkg::ADDR_PULSE_COUNT: begin
					if (pwdata[15:0] != 16'h0000) begin
						next_pulse_count = pwdata[15:0];
					end
				end
				enc_emu_pkg::ADDR_PHASE_SPEC: next_phase_spec = pwdata[1:0];
				enc_emu_pkg::ADDR_MON_SEL_1:  next_mon_sel_1  = pwdata[1:0];
				enc_emu_pkg::ADDR_MON_SEL_2:  next_mon_sel_2  = pwdata[1:0];
				default: ;
			endcase
		end
	end

	// Register the settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_count_setting   <= enc_emu_pkg::RST_PULSE_COUNT;
			phase_spec_setting    <= enc_emu_pkg::RST_PHASE_SPEC;
			monitor_select_first  <= enc_emu_pkg::RST_MON_SEL;
			monitor_select_second <= enc_emu_pkg::RST_MON_SEL;
		end else begin
			pulse_count_setting   <= next_pulse_count;
			phase_spec_setting    <= next_phase_spec;
			monitor_select_first  <= next_mon_sel_1;
			monitor_select_second <= next_mon_sel_2;
		end
	end

	// ------------------------------------------------------------
	// Divider and quadrature state
	// ------------------------------------------------------------
	logic [16:0] acc;
	logic [16:0] next_acc;
	logic [1:0]  quad;
	logic [1:0]  next_quad;
	logic [15:0] position;
	logic [15:0] next_position;
	logic        fwd;
	logic        q_step;
	logic [16:0] res17;
	logic [16:0] cnt17;

	// Widened operands for the divider compare
	assign res17 = 17'(ENC_RES);
	assign cnt17 = {1'b0, pulse_count_setting};
	// Reversal bit swaps direction to phase mapping
	assign fwd = dir_sync ^ phase_spec_setting[enc_emu_pkg::PHASE_REV_BIT];

	// Bresenham divider: add pulse count per encoder step
	always_comb begin
		next_acc      = acc;
		next_quad     = quad;
		next_position = position;
		q_step        = 1'b0;
		if (step_evt) begin
			if (dir_sync) begin
				next_position = (position == 16'(ENC_RES - 1)) ? 16'h0000
				                : position + 16'h0001;
			end else begin
				next_position = (position == 16'h0000) ? 16'(ENC_RES - 1)
				                : position - 16'h0001;
			end
			// Direct mode bypasses the divider entirely
			if (phase_spec_setting[enc_emu_pkg::SPEC_DIRECT_BIT]) begin
				q_step = 1'b1;
			end else if (acc + cnt17 >= res17) begin
				next_acc = acc + cnt17 - res17;
				q_step   = 1'b1;
			end else begin
				next_acc = acc + cnt17;
			end
			if (q_step) begin
				// Gray order 00,10,11,01 as {A,B}: A leads B when forward
				next_quad = fwd ? {~quad[0], quad[1]}
				                : {quad[0], ~quad[1]};
			end
		end
	end

	// Register divider, quadrature and position
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc      <= 17'h0_0000;
			quad     <= 2'h0;
			position <= 16'h0000;
		end else begin
			acc      <= next_acc;
			quad     <= next_quad;
			position <= next_position;
		end
	end

	// ------------------------------------------------------------
	// Zero mark pulse stretcher
	// ------------------------------------------------------------
	logic [23:0] zero_cnt;
	logic [23:0] next_zero_cnt;
	logic        zero_on;

	// One pulse per zero crossing, held for the minimum width
	// A zero edge while the mark stands is ignored
	always_comb begin
		next_zero_cnt  = zero_cnt;
		next_rev_count = rev_count;
		if (zero_evt && zero_cnt == 24'h00_0000) begin
			next_zero_cnt  = 24'(ZERO_WIDTH);
			next_rev_count = rev_count + 16'h0001;
		end else if (zero_cnt != 24'h00_0000) begin
			next_zero_cnt = zero_cnt - 24'h00_0001;
		end
	end

	// Register stretcher count and revolutions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_cnt  <= 24'h00_0000;
			rev_count <= 16'h0000;
		end else begin
			zero_cnt  <= next_zero_cnt;
			rev_count <= next_rev_count;
		end
	end

	// Mark stands while the count runs
	assign zero_on = zero_cnt != 24'h00_0000;

	// ------------------------------------------------------------
	// Differential outputs and monitors
	// ------------------------------------------------------------
	enc_emu_pkg::diff_out_t next_line;
	logic [9:0]             next_mon_1;
	logic [9:0]             next_mon_2;

	// Monitor source select, 10-bit window of each source
	function automatic logic [9:0] mon_pick(input logic [1:0]  sel,
	                                        input logic [9:0]  spd,
	                                        input logic [15:0] pos,
	                                        input logic [1:0]  q,
	                                        input logic [15:0] pc);
		logic [9:0] v;
		case (sel)
			enc_emu_pkg::MON_SPEED:       v = spd;
			enc_emu_pkg::MON_POSITION:    v = pos[15:6];
			enc_emu_pkg::MON_QUAD_STATE:  v = {8'h00, q};
			enc_emu_pkg::MON_PULSE_COUNT: v = pc[15:6];
			default:                      v = 10'h000;
		endcase
		return v;
	endfunction

	// Complement lines from the same next values
	always_comb begin
		next_line.a_true = next_quad[1];
		next_line.a_inv  = ~next_quad[1];
		next_line.b_true = next_quad[0];
		next_line.b_inv  = ~next_quad[0];
		next_line.z_true = zero_on;
		next_line.z_inv  = ~zero_on;
		next_mon_1 = mon_pick(monitor_select_first, motor_speed, position,
		                      quad, pulse_count_setting);
		next_mon_2 = mon_pick(monitor_select_second, motor_speed, position,
		                      quad, pulse_count_setting);
	end

	// Register line pairs and monitors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_out           <= 6'b010101;
			monitor_out_first  <= 10'h000;
			monitor_out_second <= 10'h000;
		end else begin
			line_out           <= next_line;
			monitor_out_first  <= next_mon_1;
			monitor_out_second <= next_mon_2;
		end
	end

endmodule

/* File: enc_emu_assertions.sv */
// Checker: line pairs, quadrature order, zero mark and monitors.
// Assumes it is bound into the emulator top; one clock domain.
module enc_emu_assertions #(
	parameter int ZERO_WIDTH = 20
) (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic                   enc_step,
	input wire logic [9:0]             motor_speed,
	input wire enc_emu_pkg::diff_out_t line_out,
	input wire logic [9:0]             monitor_out_first,
	input wire logic [9:0]             monitor_out_second
);
	logic [1:0] sel1, sel2, next_sel1, next_sel2;
	logic       step_q, wr;
	int         zcnt, scnt, next_zcnt, next_scnt;
	// ------------------------------------------------------------
	// Helper state
	// ------------------------------------------------------------
	// Select copies, zero mark length, age of last step edge
	always_comb begin
		wr = psel && penable && pwrite;
		next_sel1 = (wr && paddr == 12'h008) ? pwdata[1:0] : sel1;
		next_sel2 = (wr && paddr == 12'h00C) ? pwdata[1:0] : sel2;
		next_zcnt = line_out.z_true ? zcnt + 1 : 0;
		next_scnt = (enc_step && !step_q) ? 0 : (scnt > 99 ? scnt : scnt + 1);
	end
	// Register the helper state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{sel1, sel2, step_q} <= 5'h00;
			zcnt <= 0;
			scnt <= 100;
		end else begin
			{sel1, sel2, step_q} <= {next_sel1, next_sel2, enc_step};
			zcnt <= next_zcnt;
			scnt <= next_scnt;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Settled speed selection, not the edge that leaves reset
	sequence speed_sel(s);
		presetn && s == 2'h0 ##1 s == 2'h0 && $stable(motor_speed);
	endsequence
	AST_AB_PAIR: assert property (
		line_out.a_inv != line_out.a_true && line_out.b_inv != line_out.b_true)
		else $error("quadrature complement wrong");
	AST_Z_PAIR: assert property (line_out.z_inv != line_out.z_true)
		else $error("zero mark complement wrong");
	AST_GRAY: assert property (
		!($changed(line_out.a_true) && $changed(line_out.b_true)))
		else $error("both quadrature lines moved at once");
	AST_STEP_CAUSE: assert property (
		$changed(line_out.a_true) || $changed(line_out.b_true) |-> scnt <= 6)
		else $error("quadrature moved without an encoder step");
	AST_Z_WIDTH: assert property (
		$fell(line_out.z_true) |-> zcnt >= ZERO_WIDTH)
		else $error("zero mark too short");
	AST_Z_MAX: assert property (zcnt <= ZERO_WIDTH + 2)
		else $error("zero mark too long");
	AST_MON1: assert property (
		speed_sel(sel1) |-> monitor_out_first == motor_speed)
		else $error("first monitor not showing speed");
	AST_MON2: assert property (
		speed_sel(sel2) |-> monitor_out_second == motor_speed)
		else $error("second monitor not showing speed");
endmodule

bind encoder_pulse_output_emulator enc_emu_assertions #(
	.ZERO_WIDTH(ZERO_WIDTH)
) i_enc_emu_assertions (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .enc_step, .motor_speed, .line_out, .monitor_out_first,
	.monitor_out_second);

/* File: quad_counter_model.sv */
// Position counter model on the far side of the pulse lines.
// Assumes it samples the line pairs on pclk; no reset of its own.
module quad_counter_model (
	input wire logic                   pclk,
	input wire enc_emu_pkg::diff_out_t line_out,
	output int                         pos = 0,
	output int                         zeros = 0,
	output int                         errs = 0
);
	logic [1:0] last = 2'h0;
	logic [1:0] now;
	logic       last_z = 1'b0;
	// ------------------------------------------------------------
	// Decoder
	// ------------------------------------------------------------
	// Phase index: 00, 10, 11, 01 counts up with A leading
	assign now = {line_out.b_true, line_out.a_true ^ line_out.b_true};
	// Signed count of quarter steps and of zero marks
	always @(posedge pclk) begin
		if (now - last == 2'h1)
			pos <= pos + 1;
		else if (now - last == 2'h3)
			pos <= pos - 1;
		else if (now - last == 2'h2)
			errs <= errs + 1;
		if (line_out.z_true && !last_z)
			zeros <= zeros + 1;
		last <= now;
		last_z <= line_out.z_true;
	end
endmodule

/* File: encoder_pulse_output_emulator_tb.sv */
// Testbench for the encoder pulse output emulator.
// Assumes the package, the bound checker and the counter model.
module encoder_pulse_output_emulator_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ENC_RES = 16;
	localparam int ZW      = 20;
	logic                   pclk = 1'b0, presetn = 1'b0;
	logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]            paddr = 12'h000;
	logic [31:0]            pwdata = 32'h0, prdata, rd;
	logic                   pready, pslverr, err;
	logic                   enc_step = 1'b0, enc_zero = 1'b0;
	logic                   enc_dir_ccw = 1'b1;
	logic [9:0]             motor_speed = 10'h2A5;
	logic [9:0]             monitor_out_first, monitor_out_second;
	enc_emu_pkg::diff_out_t line_out;
	int                     pos, zeros, errs, n_fail = 0, checked = 0;
	// Free running clock
	always #5 pclk = ~pclk;
	encoder_pulse_output_emulator #(
		.ENC_RES   (ENC_RES),
		.ZERO_WIDTH(ZW)
	) i_encoder_pulse_output_emulator (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .enc_step,
		.enc_dir_ccw, .enc_zero, .motor_speed, .line_out,
		.monitor_out_first, .monitor_out_second);
	quad_counter_model i_quad_counter_model (.pclk, .line_out, .pos, .zeros,
		.errs);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			n_fail++;
			finish_test();
		end
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask
	// Slow encoder steps, well under homing creep rate
	task automatic steps(input int n, input logic ccw);
		enc_dir_ccw <= ccw;
		repeat (n) begin
			repeat (3) @(posedge pclk);
			enc_step <= 1'b1;
			repeat (3) @(posedge pclk);
			enc_step <= 1'b0;
		end
		repeat (8) @(posedge pclk);
	endtask
	task automatic zpulse();
		enc_zero <= 1'b1;
		repeat (3) @(posedge pclk);
		enc_zero <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		logic [11:0] ra [7];
		logic [31:0] rv [7];
		int          m, want, p0;
		ra = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014,
		       12'h020};
		rv = '{32'h1000, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[k]) begin
			apb(1'b0, ra[k], 32'h0);
			chk("reset value", rv[k], rd);
		end
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk("pulse count kept", 32'h1000, rd);
		$display("test registers done");
		// Divided, reversed, direct, then clockwise at a count of 4
		apb(1'b1, 12'h000, 32'h4);
		for (m = 0; m < 4; m++) begin
			apb(1'b1, 12'h004, m % 3);
			p0 = pos;
			steps(ENC_RES, m != 3);
			want = (m == 2) ? ENC_RES : 4;
			if (m == 1 || m == 3)
				want = -want;
			chk("quad steps", want, pos - p0);
		end
		chk("quad order errors", 32'h0, errs);
		$display("test quadrature done");
		// Second zero edge lands while the mark still stands
		zpulse();
		zpulse();
		repeat (ZW + 10) @(posedge pclk);
		chk("zero marks", 32'h1, zeros);
		zpulse();
		repeat (ZW + 10) @(posedge pclk);
		apb(1'b0, 12'h014, 32'h0);
		chk("revolutions", 32'h2, rd);
		$display("test zero mark done");
		apb(1'b1, 12'h00C, 32'h3);
		apb(1'b1, 12'h000, 32'h1240);
		motor_speed <= 10'h15A;
		repeat (4) @(posedge pclk);
		chk("first monitor", 32'h15A, 32'(monitor_out_first));
		chk("second monitor", 32'h49, 32'(monitor_out_second));
		$display("test monitors done");
		finish_test();
	end
endmodule
